// ===== logic/flash_if.sv
// Internal carriers between the front end and its helpers.
// Assumes all signals are on clk_in.
`timescale 1ns/1ps
interface pin_if;
    logic cs_n;
    logic cs_rise;
    logic sclk;
    logic sclk_rise;
    logic sclk_fall;
    logic si;
    logic hold_n;
    modport src(output cs_n, cs_rise, sclk, sclk_rise, sclk_fall, si, hold_n);
    modport dst(input cs_n, cs_rise, sclk, sclk_rise, sclk_fall, si, hold_n);
endinterface : pin_if

interface lock_if;
    logic upd;
    logic set;
    logic [23:0] upd_addr;
    logic [23:0] query_addr;
    logic locked;
    modport ctl(output upd, set, upd_addr, query_addr, input locked);
    modport map(input upd, set, upd_addr, query_addr, output locked);
endinterface : lock_if

// ===== logic/flash_pkg.sv
// Constants shared by the serial flash bus front end.
// Assumes a 24-bit byte address and an 8-bit opcode.
package flash_pkg;
    localparam int ADDR_BITS = 24;
    localparam int OP_BITS = 8;
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    localparam int SECT_PER_BLK = 16;
    localparam int NUM_BLOCKS = 256;
    localparam logic [7:0] TOP_BLOCK = 8'hff;
    localparam logic [7:0] BOTTOM_BLOCK = 8'h00;
    // Opcodes
    localparam logic [7:0] READ_OP = 8'h03;
    localparam logic [7:0] FAST_READ_OP = 8'h0b;
    localparam logic [7:0] DDR_FAST_READ_CMD = 8'h0d;
    localparam logic [7:0] STATUS_READ_OP = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] WRITE_EN_OP = 8'h06;
    localparam logic [7:0] WRITE_DIS_OP = 8'h04;
    localparam logic [7:0] SECTOR_ERASE_OP = 8'h20;
    localparam logic [7:0] BLOCK_ERASE_OP = 8'hd8;
    localparam logic [7:0] LOCK_OP = 8'h71;
    localparam logic [7:0] UNLOCK_OP = 8'h72;
    // Input lengths in bits, opcode included
    localparam logic [11:0] LEN_OP_ONLY = 12'h008;
    localparam logic [11:0] LEN_OP_DATA = 12'h010;
    localparam logic [11:0] LEN_OP_ADDR = 12'h020;
    // Edge counts, minus one, for opcode, address, dummy and output byte phases
    localparam logic [4:0] SDR_ADDR_LAST = 5'h17;
    localparam logic [4:0] DDR_ADDR_LAST = 5'h17;
    localparam logic [4:0] FAST_DUMMY_LAST = 5'h07;
    localparam logic [4:0] DDR_DUMMY_LAST = 5'h0b;
    localparam logic [4:0] OP_LAST = 5'h07;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // Pin reset: {cs_n, sclk, si, hold_n}
    localparam logic [3:0] PIN_RST = 4'h9;
endpackage : flash_pkg

// ===== logic/lock_map.sv
// Lock bits: 4K sectors in the end blocks, 64K units elsewhere.
// Assumes update and query addresses are stable while used.
`timescale 1ns/1ps
module lock_map #(
    parameter int NBLK = flash_pkg::NUM_BLOCKS
) (
    input wire logic clk_in,
    input wire logic srst_in,
    lock_if.map l
);
    logic [2*flash_pkg::SECT_PER_BLK-1:0] sect_lock_q;
    logic [NBLK-1:0] blk_lock_q;
    logic [7:0] ublk;
    logic [7:0] qblk;
    logic [4:0] usect;
    logic [4:0] qsect;
    logic uend;
    logic qend;

    assign ublk = l.upd_addr[flash_pkg::BLOCK_LSB +: 8];
    assign qblk = l.query_addr[flash_pkg::BLOCK_LSB +: 8];
    assign uend = ublk == flash_pkg::TOP_BLOCK ||
                  ublk == flash_pkg::BOTTOM_BLOCK;
    assign qend = qblk == flash_pkg::TOP_BLOCK ||
                  qblk == flash_pkg::BOTTOM_BLOCK;
    assign usect = {ublk[0], l.upd_addr[flash_pkg::SECTOR_LSB +: 4]};
    assign qsect = {qblk[0], l.query_addr[flash_pkg::SECTOR_LSB +: 4]};

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sect_lock_q <= '0;
            blk_lock_q <= '0;
        end else if (l.upd) begin
            if (uend) begin
                sect_lock_q[usect] <= l.set;
            end else begin
                blk_lock_q[ublk] <= l.set;
            end
        end
    end

    assign l.locked = qend ? sect_lock_q[qsect] : blk_lock_q[qblk];
endmodule : lock_map

// ===== logic/pin_sync.sv
// Two-flop synchronisers for the serial pins plus edge finding.
// Assumes clk_in is much faster than the serial clock.
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    pin_if.src p
);
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic sclk_old_q;
    logic cs_old_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_q <= flash_pkg::PIN_RST;
            sync_q <= flash_pkg::PIN_RST;
        end else begin
            meta_q <= {cs_n_in, sclk_in, si_in, hold_n_in};
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sclk_old_q <= 1'b0;
            cs_old_q <= 1'b1;
        end else begin
            sclk_old_q <= sync_q[2];
            cs_old_q <= sync_q[3];
        end
    end

    assign p.cs_n = sync_q[3];
    assign p.cs_rise = sync_q[3] & ~cs_old_q;
    assign p.sclk = sync_q[2];
    assign p.sclk_rise = sync_q[2] & ~sclk_old_q;
    assign p.sclk_fall = ~sync_q[2] & sclk_old_q;
    assign p.si = sync_q[1];
    assign p.hold_n = sync_q[0];
endmodule : pin_sync

// ===== logic/serial_flash_bus_frontend.sv
// Serial bus front end of a NOR flash, sampling the pins on clk_in.
// Assumes the host serial clock is far slower than clk_in; busy,
// quad mode, status and array data come from logic on clk_in.
// What this block does
// - Bad opcode: standby, output off
// - Good opcode: active until select rises
// - Sample on rise, launch on fall
// - Clock modes 0 and 3 both work
// - Double rate read uses both edges
// - Reads end cleanly at any bit
// - Off-boundary write command is dropped
// - Array access ignored while busy
// - Pause starts with clock low
// - Pause ends with clock low
// - Paused: output off, pins ignored
// - Pause leaves internal operations running
// - Select high while paused resets interface
// - No pause in quad mode
// - 4K sectors and 64K blocks
// - End blocks lock per sector
// - Other blocks lock per 64K
`timescale 1ns/1ps
module serial_flash_bus_frontend (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    input wire logic quad_mode_in,
    input wire logic busy_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] rd_data_in,
    output logic so_out,
    output logic so_oe_out,
    output logic active_out,
    output logic standby_out,
    output logic hold_out,
    output logic ddr_out,
    output logic [23:0] rd_addr_out,
    output logic rd_next_out,
    output logic exec_out,
    output logic [7:0] exec_op_out,
    output logic [23:0] exec_addr_out,
    output logic [7:0] exec_data_out
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_OPC = 7'b0000010,
        ST_ADDR = 7'b0000100,
        ST_DUMMY = 7'b0001000,
        ST_OUT = 7'b0010000,
        ST_WIN = 7'b0100000,
        ST_STBY = 7'b1000000
    } state_e;

    pin_if pins();
    lock_if lk();

    state_e st_q;
    logic hold_q;
    logic live;
    logic rise_ev;
    logic fall_ev;
    logic in_ev;
    logic out_ev;
    logic [7:0] opc;
    logic [7:0] op_q;
    logic [4:0] cnt_q;
    logic [11:0] bits_q;
    logic [11:0] need_q;
    logic [23:0] in_sh_q;
    logic [23:0] addr_q;
    logic [6:0] osh_q;
    logic [2:0] obit_q;
    logic [7:0] obyte;
    logic ddr_q;
    logic fast_q;
    logic stat_src_q;
    logic wcls_q;
    logic exec_ok;
    logic is_erase;
    logic load;

    pin_sync u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .cs_n_in(cs_n_in),
        .sclk_in(sclk_in),
        .si_in(si_in),
        .hold_n_in(hold_n_in),
        .p(pins.src)
    );

    lock_map u_lock (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .l(lk.map)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in || pins.cs_n || quad_mode_in) begin
            hold_q <= 1'b0;
        end else if (!pins.sclk) begin
            hold_q <= !pins.hold_n;
        end
    end

    // Clock and data ignored while paused
    assign live = !hold_q && !pins.cs_n;
    // Same edges whatever the idle level
    assign rise_ev = pins.sclk_rise && live;
    assign fall_ev = pins.sclk_fall && live;
    // Both edges count in double rate
    assign in_ev = rise_ev || (ddr_q && fall_ev);
    assign out_ev = fall_ev || (ddr_q && rise_ev);
    // Newest bit enters at the bottom
    assign opc = {in_sh_q[6:0], pins.si};
    assign load = st_q == ST_OUT && out_ev && obit_q == '0;
    assign obyte = stat_src_q ? status_in : rd_data_in;
    assign is_erase = op_q == flash_pkg::SECTOR_ERASE_OP ||
                      op_q == flash_pkg::BLOCK_ERASE_OP;

    // Command sequencer
    always_ff @(posedge clk_in) begin
        if (srst_in || pins.cs_n) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    st_q <= ST_OPC;
                end
                ST_OPC: if (in_ev) begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == flash_pkg::OP_LAST) begin
                        cnt_q <= '0;
                        unique case (opc)
                            flash_pkg::READ_OP,
                            flash_pkg::FAST_READ_OP,
                            flash_pkg::DDR_FAST_READ_CMD:
                                st_q <= busy_in ? ST_STBY : ST_ADDR;
                            flash_pkg::STATUS_READ_OP:
                                st_q <= ST_OUT;
                            flash_pkg::WRITE_EN_OP,
                            flash_pkg::WRITE_DIS_OP,
                            flash_pkg::STATUS_WRITE_CMD,
                            flash_pkg::SECTOR_ERASE_OP,
                            flash_pkg::BLOCK_ERASE_OP,
                            flash_pkg::LOCK_OP,
                            flash_pkg::UNLOCK_OP:
                                st_q <= busy_in ? ST_STBY : ST_WIN;
                            default: st_q <= ST_STBY;
                        endcase
                    end
                end
                ST_ADDR: if (in_ev) begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == (ddr_q ? flash_pkg::DDR_ADDR_LAST :
                                  flash_pkg::SDR_ADDR_LAST)) begin
                        cnt_q <= '0;
                        st_q <= (ddr_q || fast_q) ? ST_DUMMY : ST_OUT;
                    end
                end
                ST_DUMMY: if (in_ev) begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == (ddr_q ? flash_pkg::DDR_DUMMY_LAST :
                                  flash_pkg::FAST_DUMMY_LAST)) begin
                        st_q <= ST_OUT;
                    end
                end
                ST_OUT, ST_WIN, ST_STBY: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // Decode flags, fixed at the eighth bit
    always_ff @(posedge clk_in) begin
        if (srst_in || pins.cs_n) begin
            op_q <= '0;
            ddr_q <= 1'b0;
            fast_q <= 1'b0;
            stat_src_q <= 1'b0;
            wcls_q <= 1'b0;
            need_q <= flash_pkg::LEN_OP_ONLY;
        end else if (st_q == ST_OPC && in_ev &&
                     cnt_q == flash_pkg::OP_LAST) begin
            op_q <= opc;
            ddr_q <= opc == flash_pkg::DDR_FAST_READ_CMD;
            fast_q <= opc == flash_pkg::FAST_READ_OP;
            stat_src_q <= opc == flash_pkg::STATUS_READ_OP;
            wcls_q <= !busy_in;
            if (opc == flash_pkg::STATUS_WRITE_CMD) begin
                need_q <= flash_pkg::LEN_OP_DATA;
            end else if (opc == flash_pkg::WRITE_EN_OP ||
                         opc == flash_pkg::WRITE_DIS_OP) begin
                need_q <= flash_pkg::LEN_OP_ONLY;
            end else begin
                need_q <= flash_pkg::LEN_OP_ADDR;
            end
        end
    end

    // Input shifter and bit count
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            in_sh_q <= '0;
            bits_q <= '0;
        end else if (pins.cs_n) begin
            bits_q <= '0;
        end else if (in_ev && (st_q == ST_OPC || st_q == ST_WIN)) begin
            in_sh_q <= {in_sh_q[22:0], pins.si};
            bits_q <= bits_q + 12'h001;
        end
    end

    // Array address, loaded then stepped per byte
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            addr_q <= '0;
        end else if (st_q == ST_ADDR && in_ev) begin
            addr_q <= {addr_q[22:0], pins.si};
        end else if (load && !stat_src_q) begin
            addr_q <= addr_q + 24'h000001;
        end
    end

    // Output shifter; select rise simply stops it
    // Any bit may be the last one
    always_ff @(posedge clk_in) begin
        if (srst_in || pins.cs_n) begin
            so_out <= 1'b0;
            osh_q <= '0;
            obit_q <= '0;
            rd_next_out <= 1'b0;
        end else begin
            rd_next_out <= load && !stat_src_q;
            if (load) begin
                so_out <= obyte[7];
                osh_q <= obyte[6:0];
                obit_q <= flash_pkg::BYTE_LAST;
            end else if (st_q == ST_OUT && out_ev) begin
                so_out <= osh_q[6];
                osh_q <= {osh_q[5:0], 1'b0};
                obit_q <= obit_q - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            so_oe_out <= 1'b0;
        end else begin
            so_oe_out <= st_q == ST_OUT && live;
        end
    end

    // Whole bytes of full length only
    // Select rise while paused abandons it
    // Boundary check guards against host slip
    assign exec_ok = pins.cs_rise && !hold_q && st_q == ST_WIN &&
                     wcls_q && bits_q[2:0] == 3'h0 && bits_q >= need_q &&
                     !(is_erase && lk.locked);

    // Execution handed out, never cancelled here
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            exec_out <= 1'b0;
            exec_op_out <= '0;
            exec_addr_out <= '0;
            exec_data_out <= '0;
        end else begin
            exec_out <= exec_ok;
            if (exec_ok) begin
                exec_op_out <= op_q;
                exec_addr_out <= in_sh_q;
                exec_data_out <= in_sh_q[7:0];
            end
        end
    end

    assign lk.query_addr = in_sh_q;
    assign lk.upd_addr = exec_addr_out;
    assign lk.set = exec_op_out == flash_pkg::LOCK_OP;
    assign lk.upd = exec_out && (exec_op_out == flash_pkg::LOCK_OP ||
                                 exec_op_out == flash_pkg::UNLOCK_OP);

    // Active from good opcode to select rise
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            active_out <= 1'b0;
            standby_out <= 1'b0;
            hold_out <= 1'b0;
            ddr_out <= 1'b0;
            rd_addr_out <= '0;
        end else begin
            active_out <= !pins.cs_n && (st_q == ST_ADDR ||
                          st_q == ST_DUMMY || st_q == ST_OUT ||
                          st_q == ST_WIN);
            standby_out <= st_q == ST_STBY || (standby_out &&
                           !(st_q == ST_IDLE && !pins.cs_n));
            hold_out <= hold_q;
            ddr_out <= ddr_q;
            rd_addr_out <= addr_q;
        end
    end
endmodule : serial_flash_bus_frontend

// ===== verif/host_ctrl_model.sv
// Host serial controller model driving select, clock, data, pause.
// Assumes the bench sets idle and calls frame; cap holds sampled bits.
`timescale 1ns/1ps
module host_ctrl_model (
    input wire logic so_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic si_out,
    output logic hold_n_out
);
    logic [63:0] cap;
    bit idle;
    bit ddr_ph;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        si_out = 1'b0;
        hold_n_out = 1'b1;
    end
    task automatic tick(input logic b);
        si_out = b;
        #31.25;
        if (ddr_ph || !sclk_out) cap = {cap[62:0], so_in};
        sclk_out = ~sclk_out;
        #31.25;
    endtask : tick
    // pause only with the clock low
    task automatic pause(input bit jig);
        hold_n_out = 1'b0;
        #200;
        repeat (jig ? 2 : 0) begin
            si_out = ~si_out;
            #62.5 sclk_out = ~sclk_out;
        end
        #200 hold_n_out = 1'b1;
        #100;
    endtask : pause
    // msb first; nb may miss a byte on purpose
    task automatic frame(input logic [63:0] d, input int nb,
            input int nrd, input bit dd, input int hb);
        cap = '0;
        // Idle level settles before select falls
        sclk_out = idle;
        #40 cs_n_out = 1'b0;
        #62.5;
        for (int i = 0; i < nb + nrd; i++) begin
            if (i == hb) pause(1'b1);
            // Double rate address starts on the fall after the opcode
            ddr_ph = dd && i >= 7;
            tick(i < nb ? d[nb - 1 - i] : ~si_out);
            if (!ddr_ph) tick(si_out);
        end
        if (hb == nb + nrd) hold_n_out = 1'b0;
        #62.5;
        cs_n_out = 1'b1;
        // Released line shows the inverse, not a held value
        si_out = ~si_out;
        ddr_ph = 1'b0;
        // pause pin high before the next select
        #40 hold_n_out = 1'b1;
        sclk_out = idle;
        #100;
    endtask : frame
endmodule : host_ctrl_model

// ===== verif/serial_flash_bus_frontend_asserts.sv
// Port checker for the flash bus front end, bound below.
// Assumes one clk_in domain reset by srst_in.
`timescale 1ns/1ps
module serial_flash_bus_frontend_asserts (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic quad_mode_in,
    input wire logic busy_in,
    input wire logic so_oe_out,
    input wire logic standby_out,
    input wire logic hold_out,
    input wire logic rd_next_out,
    input wire logic exec_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    refused_quiet_a:
        assert property (standby_out |-> !so_oe_out)
        else $error("output on in standby");
    pause_quiet_a:
        assert property (hold_out [*6] |-> !so_oe_out)
        else $error("output on in pause");
    pause_frozen_a:
        assert property (hold_out [*4] |-> !rd_next_out)
        else $error("read step in pause");
    quad_nopause_a:
        assert property (quad_mode_in && $past(quad_mode_in) |=> !hold_out)
        else $error("pause in quad mode");
    exec_after_cs_a:
        assert property (exec_out |-> cs_n_in ##1 !exec_out)
        else $error("bad execute pulse");
    busy_noread_a:
        assert property (busy_in && $past(busy_in) |-> !rd_next_out)
        else $error("array read while busy");
    busy_noexec_a:
        assert property (busy_in [*8] |-> !exec_out)
        else $error("execute while busy");
    oe_with_cs_a:
        assert property (cs_n_in [*6] |-> !so_oe_out)
        else $error("output on after select");
endmodule : serial_flash_bus_frontend_asserts

bind serial_flash_bus_frontend serial_flash_bus_frontend_asserts chk_inst (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n_in),
    .quad_mode_in(quad_mode_in), .busy_in(busy_in),
    .so_oe_out(so_oe_out), .standby_out(standby_out),
    .hold_out(hold_out), .rd_next_out(rd_next_out),
    .exec_out(exec_out)
);

// ===== verif/serial_flash_bus_frontend_tb_top.sv
// Bench for the flash bus front end: host model on the pins,
// reads and executions predicted here and queued for comparison.
`timescale 1ns/1ps
module serial_flash_bus_frontend_tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic quad_mode_in = 1'b0;
    logic busy_in = 1'b0;
    logic [7:0] status_in = 8'h00;
    logic [7:0] rd_data_in, exec_op_out, exec_data_out;
    logic cs_n, sclk, si, hold_n, so_out, so_oe_out, active_out;
    logic standby_out, hold_out, ddr_out, rd_next_out, exec_out;
    logic [23:0] rd_addr_out, exec_addr_out, a;
    logic [4:0] seen = 5'h00;
    logic [15:0] r = 16'h002a;
    logic [39:0] exq[$];
    logic [39:0] wv[20];
    int wn[20];
    bit we[20];
    bit clr;
    int n_fail, comparisons;
    always #4 clk_in = ~clk_in;
    serial_flash_bus_frontend serial_flash_bus_frontend_inst (
        .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .si_in(si), .hold_n_in(hold_n),
        .quad_mode_in(quad_mode_in), .busy_in(busy_in),
        .status_in(status_in), .rd_data_in(rd_data_in),
        .so_out(so_out), .so_oe_out(so_oe_out), .active_out(active_out),
        .standby_out(standby_out), .hold_out(hold_out),
        .ddr_out(ddr_out), .rd_addr_out(rd_addr_out),
        .rd_next_out(rd_next_out), .exec_out(exec_out),
        .exec_op_out(exec_op_out), .exec_addr_out(exec_addr_out),
        .exec_data_out(exec_data_out)
    );
    host_ctrl_model host (
        .so_in(so_out), .cs_n_out(cs_n), .sclk_out(sclk),
        .si_out(si), .hold_n_out(hold_n)
    );
    function automatic logic [7:0] mem_f(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5a;
    endfunction : mem_f
    function automatic logic [63:0] rd_exp(input logic [23:0] x, int n);
        logic [63:0] v;
        v = '0;
        for (int i = 0; i < n; i++) v = {v[55:0], mem_f(x + 24'(i))};
        return v;
    endfunction : rd_exp
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    assign rd_data_in = mem_f(rd_addr_out);
    always @(posedge clk_in) begin
        seen <= clr ? 5'h00 : seen | {standby_out, active_out, hold_out,
            ddr_out, so_oe_out};
        if (exec_out) exq.push_back({exec_op_out, exec_addr_out,
            exec_data_out});
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic [63:0] d, int nb, int nrd, bit dd,
            int hb);
        @(negedge clk_in) clr = 1'b1;
        @(negedge clk_in) clr = 1'b0;
        exq.delete();
        host.frame(d, nb, nrd, dd, hb);
        repeat (8) @(negedge clk_in);
    endtask : run
    task automatic print_verdict;
        $display("checks %0d fails %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        // Tests need roughly 130 us; this leaves ample margin
        #400000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (4) @(negedge clk_in);
        chk({so_oe_out, active_out, exec_out}, 3'h0);
        repeat (8) @(negedge clk_in);
        srst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        for (int m = 0; m < 2; m++) begin
            host.idle = (m == 1);
            r = lfsr(r);
            a = {r[7:0], r};
            run({flash_pkg::READ_OP, a}, 32, 24, 0, m ? -1 : 20);
            chk(host.cap[23:0], rd_exp(a, 3));
            chk(seen[2], m == 0);
        end
        host.idle = 1'b0;
        run({flash_pkg::READ_OP, a}, 32, 13, 0, -1);
        chk(host.cap[12:0], rd_exp(a, 2) >> 3);
        run({flash_pkg::FAST_READ_OP, a, 8'h00}, 40, 16, 0, 44);
        chk(host.cap[15:0], rd_exp(a, 2));
        run({flash_pkg::DDR_FAST_READ_CMD, a, 12'h000}, 44, 17, 1, -1);
        chk({seen[1], host.cap[15:0]}, {1'b1, 16'(rd_exp(a, 2))});
        @(negedge clk_in) status_in = r[15:8];
        run(flash_pkg::STATUS_READ_OP, 8, 16, 0, -1);
        chk({seen[3], host.cap[15:0]}, {1'b1, {2{r[15:8]}}});
        run(8'hc3, 8, 16, 0, -1);
        chk({seen[4], seen[3], seen[0], standby_out}, 4'h9);
        // Write-class table: value, bit count, executes or not
        wv = '{40'h06, 40'h04, 40'h0600, 40'h01a5, 40'h060, 40'h2001234,
            40'h01, 40'h200000, 40'h20000000, 40'hd87f0000, 40'h71001000,
            40'h20001abc, 40'h20002000, 40'h71023000, 40'h2002f000,
            40'h71ff5000, 40'h20ff6000, 40'h20ff5fff, 40'h72ff5000,
            40'h20ff5000};
        wn = '{8, 8, 16, 16, 12, 28, 8, 24, 32, 32, 32, 32, 32, 32, 32, 32,
            32, 32, 32, 32};
        we = '{1, 1, 1, 1, 0, 0, 0, 0, 1, 1, 1, 0, 1, 1, 0, 1, 1, 0, 1, 1};
        for (int i = 0; i < 20; i++) begin
            run(wv[i], wn[i], 0, 0, -1);
            chk(exq.size(), we[i]);
            if (we[i] && exq.size() > 0) begin
                chk(exq[0][39:32], wv[i][wn[i] - 1 -: 8]);
                chk(exq[0][7:0], wv[i][7:0]);
                if (wn[i] == 32) chk(exq[0][31:8], wv[i][23:0]);
            end
        end
        chk(standby_out, 1'b0);
        @(negedge clk_in) busy_in = 1'b1;
        repeat (10) @(negedge clk_in);
        run({flash_pkg::SECTOR_ERASE_OP, 24'h000000}, 32, 0, 0, -1);
        chk(exq.size(), 0);
        run({flash_pkg::READ_OP, a}, 32, 8, 0, -1);
        chk({seen[4], seen[0]}, 2'h2);
        run(flash_pkg::STATUS_READ_OP, 8, 8, 0, 4);
        chk(host.cap[7:0], r[15:8]);
        @(negedge clk_in) busy_in = 1'b0;
        run(flash_pkg::WRITE_EN_OP, 8, 0, 0, 8);
        chk(exq.size(), 0);
        @(negedge clk_in) quad_mode_in = 1'b1;
        run(flash_pkg::WRITE_EN_OP, 8, 0, 0, 4);
        chk({seen[2], exq.size() == 0}, 2'h1);
        @(negedge clk_in) quad_mode_in = 1'b0;
        run(flash_pkg::WRITE_EN_OP, 8, 0, 0, 4);
        chk(exq.size(), 1);
        print_verdict();
    end
endmodule : serial_flash_bus_frontend_tb_top
